/* File: hw/fpcb_top.sv */
// APB register bank for trim, protection arming, thresholds and alarm flags
//
// How it works
// - Eight-bit read/write bias trim code, resets to zero for nominal current.
// - Trim bit 7 chooses direction: zero reduces, one increases current.
// - Trim bits 6:0 carry the magnitude, passed unchanged to the analog side.
// - Source overcurrent arm bit 7 resets to zero; one enables source monitoring.
// - Source overcurrent threshold in bits 6:0, read/write, resets to zero.
// - Sink overcurrent arm bit 7 resets to zero; one enables sink monitoring.
// - Sink overcurrent threshold in bits 6:0, read/write, resets to zero.
// - Positive overvoltage arm bit 7 resets to zero; one enables monitoring.
// - Positive overvoltage threshold in bits 6:0, read/write, resets to zero.
// - Negative overvoltage arm bit 7 resets to zero; one enables monitoring.
// - Negative overvoltage threshold in bits 6:0, read/write, resets to zero.
// - Overtemperature register: arm bit 7 off at reset, threshold 6:0 zero.
// - Source hold bit 4 zero: source flag follows fault and self-clears.
// - Source hold bit 4 one: source flag set by fault, held afterwards.
// - Sink hold bit 3 zero: sink flag follows fault and self-clears.
// - Sink hold bit 3 one: sink flag set by fault, held until cleared.
// - Latched flag clears on a written one or when its hold bit is written zero; a zero written to status leaves it.
// - Armed detected fault shuts down the driver, as does the shutdown pin.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "fpcb_params.svh"

module fpcb_top #(
   parameter int ADDR_W = `FPCB_ADDR_W,
   parameter int SYNC_STAGES = `FPCB_SYNC_STAGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] fault_raw,
   input wire logic external_shutdown_pin,
   output fpcb_pkg::fpcb_cfg_t cfg,
   output logic [4:0] alarm_flags,
   output logic hv_shutdown
);

   if (ADDR_W < `FPCB_ADDR_W) begin : g_chk_addr
      $error("fpcb_top: ADDR_W too narrow for the register map");
   end
   if (SYNC_STAGES < 2) begin : g_chk_sync
      $error("fpcb_top: SYNC_STAGES must be at least 2");
   end

   // Byte offset of protection register idx; source sits lowest
   function automatic logic [7:0] prot_offset(input int idx);
      logic [7:0] step_count;
      step_count = 8'(`FPCB_IDX_SRC - idx);
      prot_offset = 8'(`FPCB_OFS_PROT_BASE + step_count * `FPCB_OFS_PROT_STEP);
   endfunction : prot_offset

   fpcb_pkg::fpcb_cfg_t cfg_reg;
   fpcb_pkg::fpcb_cfg_t cfg_next;
   logic [4:0] flag_reg;
   logic [4:0] flag_next;
   logic shut_reg;
   logic shut_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pslverr_reg;
   logic [4:0] sync_reg [SYNC_STAGES];

   // Bus phase decode
   wire logic [7:0] addr_lo = paddr[7:0];
   wire logic upper_zero = (paddr >> 8) == '0;
   wire logic acc_wait = psel & penable & ~pready_reg;
   wire logic commit = psel & penable & pready_reg;
   wire logic wr_commit = commit & pwrite;

   // Address decode
   wire logic sel_trim = upper_zero & (addr_lo == `FPCB_OFS_TRIM);
   wire logic sel_spare = upper_zero & (addr_lo == `FPCB_OFS_SPARE);
   wire logic sel_hold = upper_zero & (addr_lo == `FPCB_OFS_HOLD);
   wire logic sel_status = upper_zero & (addr_lo == `FPCB_OFS_STATUS);
   logic [4:0] sel_prot;
   for (genvar i = 0; i < `FPCB_NUM_PROT; i++) begin : g_dec
      assign sel_prot[i] = upper_zero & (addr_lo == prot_offset(i));
   end
   wire logic mapped = sel_trim | sel_spare | sel_hold | sel_status | (|sel_prot);

   // Fault path
   wire logic [4:0] fault_sync = sync_reg[SYNC_STAGES-1];
   logic [4:0] arm_vec;
   for (genvar i = 0; i < `FPCB_NUM_PROT; i++) begin : g_arm
      assign arm_vec[i] = cfg_reg.prot[i].enable;
   end
   wire logic [4:0] fault_armed = fault_sync & arm_vec;
   wire logic [4:0] hold_vec = {cfg_reg.source_alarm_hold_enable,
                                cfg_reg.sink_alarm_hold_enable, 3'b000};
   wire logic [4:0] flag_clr = (wr_commit & sel_status) ? pwdata[4:0] : 5'h00;

   // Set beats clear so a fault in the clearing cycle is kept
   for (genvar i = 0; i < `FPCB_NUM_PROT; i++) begin : g_flag
      assign flag_next[i] = hold_vec[i] ? (fault_armed[i] | (flag_reg[i] & ~flag_clr[i]))
                                        : fault_armed[i];
   end

   // Held flags keep the driver down until software clears them
   assign shut_next = external_shutdown_pin | (|fault_armed)
                    | (|(flag_reg & hold_vec & ~flag_clr));

   // Register writes
   always_comb begin
      cfg_next = cfg_reg;
      if (wr_commit & sel_trim) begin
         cfg_next.bias_trim_code = pwdata[7:0];
      end
      for (int i = 0; i < `FPCB_NUM_PROT; i++) begin
         if (wr_commit & sel_prot[i]) begin
            cfg_next.prot[i].enable = pwdata[`FPCB_BIT_ARM];
            cfg_next.prot[i].threshold = pwdata[6:0];
         end
      end
      if (wr_commit & sel_hold) begin
         cfg_next.source_alarm_hold_enable = pwdata[`FPCB_BIT_SRC_HOLD];
         cfg_next.sink_alarm_hold_enable = pwdata[`FPCB_BIT_SNK_HOLD];
      end
   end

   // Read mux; reserved bits and the spare register read zero
   always_comb begin
      prdata_next = 32'h0000_0000;
      if (sel_trim) begin
         prdata_next[7:0] = cfg_reg.bias_trim_code;
      end
      for (int i = 0; i < `FPCB_NUM_PROT; i++) begin
         if (sel_prot[i]) begin
            prdata_next[7:0] = cfg_reg.prot[i];
         end
      end
      if (sel_hold) begin
         prdata_next[`FPCB_BIT_SRC_HOLD] = cfg_reg.source_alarm_hold_enable;
         prdata_next[`FPCB_BIT_SNK_HOLD] = cfg_reg.sink_alarm_hold_enable;
      end
      if (sel_status) begin
         prdata_next[`FPCB_BIT_SHUTDOWN] = shut_reg;
         prdata_next[4:0] = flag_reg;
      end
   end

   // Spare register writes are dropped quietly; unmapped addresses return pslverr

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < SYNC_STAGES; k++) begin
            sync_reg[k] <= 5'h00;
         end
      end else begin
         sync_reg[0] <= fault_raw;
         for (int k = 1; k < SYNC_STAGES; k++) begin
            sync_reg[k] <= sync_reg[k-1];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg.bias_trim_code <= `FPCB_RST_TRIM;
         cfg_reg.prot <= {`FPCB_NUM_PROT{`FPCB_RST_PROT}};
         cfg_reg.source_alarm_hold_enable <= `FPCB_RST_HOLD;
         cfg_reg.sink_alarm_hold_enable <= `FPCB_RST_HOLD;
         flag_reg <= `FPCB_RST_FLAG;
         shut_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         flag_reg <= flag_next;
         shut_reg <= shut_next;
      end
   end

   // One wait state: data and error are loaded as pready rises
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= acc_wait;
         if (acc_wait) begin
            pslverr_reg <= ~mapped;
            prdata_reg <= (pwrite | ~mapped) ? 32'h0000_0000 : prdata_next;
         end else begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign cfg = cfg_reg;
   assign alarm_flags = flag_reg;
   assign hv_shutdown = shut_reg;

endmodule : fpcb_top

/* File: pkg/fpcb_params.svh */
// Offsets, field positions, reset values and widths of the protection bank
`ifndef FPCB_PARAMS_SVH
`define FPCB_PARAMS_SVH

`define FPCB_ADDR_W 8
`define FPCB_OFS_TRIM 8'h00
`define FPCB_OFS_SPARE 8'h04
`define FPCB_OFS_PROT_BASE 8'h08
`define FPCB_OFS_PROT_STEP 8'h04
`define FPCB_OFS_HOLD 8'h1C
`define FPCB_OFS_STATUS 8'h20

`define FPCB_NUM_PROT 5
`define FPCB_IDX_SRC 4
`define FPCB_IDX_SNK 3
`define FPCB_IDX_POS 2
`define FPCB_IDX_NEG 1
`define FPCB_IDX_OT 0

`define FPCB_BIT_ARM 7
`define FPCB_BIT_TRIM_DIR 7
`define FPCB_BIT_SRC_HOLD 4
`define FPCB_BIT_SNK_HOLD 3
`define FPCB_BIT_SHUTDOWN 7

`define FPCB_RST_TRIM 8'h00
`define FPCB_RST_PROT 8'h00
`define FPCB_RST_HOLD 1'b0
`define FPCB_RST_FLAG 5'h00
`define FPCB_SYNC_STAGES 2

`endif

/* File: pkg/fpcb_pkg.sv */
// Types shared by the protection configuration bank
package fpcb_pkg;

   typedef struct packed {
      logic enable;
      logic [6:0] threshold;
   } fpcb_prot_t;

   typedef struct packed {
      logic [7:0] bias_trim_code;
      fpcb_prot_t [4:0] prot;
      logic source_alarm_hold_enable;
      logic sink_alarm_hold_enable;
   } fpcb_cfg_t;

endpackage : fpcb_pkg

/* File: bench/fpcb_asserts.sv */
// Port-level checks for the protection bank
`timescale 1ns/100ps
module fpcb_asserts #(
   parameter int ADDR_W = 8,
   parameter int SYNC_STAGES = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [4:0] fault_raw,
   input wire logic external_shutdown_pin,
   input wire fpcb_pkg::fpcb_cfg_t cfg,
   input wire logic [4:0] alarm_flags,
   input wire logic hv_shutdown
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic wr = psel && penable && pready && pwrite;
   wire logic st = wr && paddr == 8'h20;
   wire logic hwr = wr && paddr == 8'h1C;
   trim_write_a:
   assert property (wr && paddr == 8'h00 |=> cfg.bias_trim_code == $past(pwdata[7:0])) else $error("trim");
   src_cfg_a:
   assert property (wr && paddr == 8'h08 |=> cfg.prot[4] == $past(pwdata[7:0])) else $error("src cfg");
   ot_cfg_a:
   assert property (wr && paddr == 8'h18 |=> cfg.prot[0] == $past(pwdata[7:0])) else $error("ot cfg");
   flag_sync_a:
   assert property (alarm_flags[2] |-> $past(fault_raw[2], 3)) else $error("flag cause");
   src_follow_a:
   assert property (!cfg.source_alarm_hold_enable && !$past(cfg.source_alarm_hold_enable)
      && alarm_flags[4] |-> $past(fault_raw[4], 3)) else $error("src follow");
   src_hold_a:
   assert property (alarm_flags[4] && cfg.source_alarm_hold_enable && !(st && pwdata[4]) && !hwr
      |=> alarm_flags[4]) else $error("src hold");
   snk_hold_a:
   assert property (alarm_flags[3] && cfg.sink_alarm_hold_enable && !(st && pwdata[3]) && !hwr
      |=> alarm_flags[3]) else $error("snk hold");
   pin_shut_a:
   assert property (external_shutdown_pin |=> hv_shutdown) else $error("pin shutdown");
   flag_shut_a:
   assert property (alarm_flags != 5'h00 |-> hv_shutdown) else $error("flag shutdown");
endmodule : fpcb_asserts
bind fpcb_top fpcb_asserts #(.ADDR_W(ADDR_W), .SYNC_STAGES(SYNC_STAGES)) u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .fault_raw, .external_shutdown_pin,
   .cfg, .alarm_flags, .hv_shutdown);

/* File: bench/test_fault_protection_config_bank.sv */
// Self-checking bench for the protection bank
`timescale 1ns/100ps
module test_fault_protection_config_bank;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic pready, pslverr, external_shutdown_pin = 0, hv_shutdown;
   logic [4:0] fault_raw = 5'h00, alarm_flags;
   fpcb_pkg::fpcb_cfg_t cfg;
   int n_mismatch = 0, n_compared = 0;
   always #25 pclk = ~pclk;
   fpcb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .fault_raw, .external_shutdown_pin, .cfg, .alarm_flags, .hv_shutdown);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic flt(input logic [4:0] f, input logic [4:0] exp);
      fault_raw <= f;
      repeat (4) @(posedge pclk);
      chk(alarm_flags, exp);
   endtask : flt
   task automatic tally_and_finish;
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      void'($urandom(92));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk(err, i == 9);
      end
      // Spare word skipped: software keeps off it
      for (int i = 0; i < 8; i++) begin
         if (i == 1) continue;
         d = $urandom & (i == 7 ? 32'h18 : 32'hFF);
         apb(1'b1, 8'(i * 4), d);
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, d);
      end
      for (int i = 2; i < 7; i++) apb(1'b1, 8'(i * 4), 32'h80);
      apb(1'b1, 8'h1C, 32'h18);
      flt(5'h1F, 5'h1F);
      chk(hv_shutdown, 1'b1);
      flt(5'h00, 5'h18);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h98);
      apb(1'b1, 8'h20, 32'h0);
      chk(alarm_flags, 5'h18);
      apb(1'b1, 8'h20, 32'h10);
      chk(alarm_flags, 5'h08);
      apb(1'b1, 8'h20, 32'h08);
      apb(1'b1, 8'h1C, 32'h0);
      flt(5'h18, 5'h18);
      flt(5'h00, 5'h00);
      apb(1'b1, 8'h08, 32'h0);
      flt(5'h1F, 5'h0F);
      flt(5'h00, 5'h00);
      external_shutdown_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(hv_shutdown, 1'b1);
      external_shutdown_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(hv_shutdown, 1'b0);
      tally_and_finish();
   end
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : test_fault_protection_config_bank
